// [rtl/exc_seq.v]
// Exception sequencer top: times exception entry, reset instruction,
// fault frame saves and frame restores, and hosts the coprocessor agent.
// Assumes start requests synchronous to clk and held for one cycle.
//
// What this block does
// - Interrupt entry on interrupt stack: 26 clocks best, 33 worst.
// - Interrupt entry on master stack: 41 clocks best, 48 worst.
// - Reset instruction: 518 clocks, no operand traffic; 519 worst.
// - Short fault frame save: 42 best, 50 worst, 1 read 10 writes.
// - Long fault frame save: 79 clocks best, 86 worst, 1 read and 24 writes.
// - Short fault frame return: 42 best, 43 cache, 10 reads.
// - Long fault frame return: 91 best, 92 cache, 24 reads.
// - Throwaway frame return chains into a second-frame return.
// - Processor performs coprocessor transfers as async bus cycles.
// - Coprocessor transfers get normal fault and arbitration handling.
// - Up to seven coprocessors, each with its own id.
// - Coprocessor handshake needs no shared clock phase.
`timescale 1ns/1ps
`include "exc_seq_map.vh"
module exc_seq (
   // Clock and reset
   input  wire        clk,
   input  wire        rstn,
   // Operation request
   input  wire        start,
   input  wire [2:0]  op,
   input  wire [1:0]  timing_case,  // 0 best, 1 cache, 2 worst
   input  wire [2:0]  next_op,      // Second frame after a throwaway
   output reg         busy_q,
   output reg         done_q,
   output reg  [9:0]  clocks_q,     // Clocks used by the finished operation
   // Bus cycle strobes and reset output of the sequence
   output reg         rd_cyc_q,
   output reg         pf_cyc_q,
   output reg         wr_cyc_q,
   output reg         reset_out_q,
   // Coprocessor request
   input  wire        cp_req,
   input  wire [2:0]  cp_id,
   input  wire        cp_write,
   input  wire [31:0] cp_wdata,
   output wire        cp_done,
   output wire        cp_err,
   output wire [31:0] cp_rdata,
   // Async bus
   input  wire        bus_grant,
   output wire        as_n,
   output wire        rw,
   output wire [2:0]  sel_id,
   output wire [31:0] bus_wdata,
   input  wire        dsack_n,
   input  wire        berr_n,
   input  wire        addr_fault,
   input  wire [31:0] bus_rdata,
   // Coprocessor width straps, tied high for 32-bit operation
   output reg         lowest_address_input_q,
   output reg         width_select_q
);
   localparam IDLE = 2'd0;
   localparam RUN  = 2'd1;
   localparam FIN  = 2'd2;

   reg [1:0]  st_q;
   reg [2:0]  op_q;
   reg [2:0]  next_q;
   reg        chain_q;
   reg [1:0]  case_q;
   reg [9:0]  left_q;
   reg [9:0]  used_q;
   reg [4:0]  rd_left_q;
   reg [4:0]  wr_left_q;
   reg [1:0]  pf_left_q;

   // Total clocks for an operation in a timing case
   function [9:0] budget;
      input [2:0] o;
      input [1:0] c;
      reg   [9:0] b;
      reg   [9:0] x;
      begin
         b = `CLK_INT_I_BEST;
         x = `CLK_INT_I_XTRA;
         case (o)
            `OP_INT_ISTACK:  begin b = `CLK_INT_I_BEST; x = `CLK_INT_I_XTRA; end
            `OP_INT_MSTACK:  begin b = `CLK_INT_M_BEST; x = `CLK_INT_M_XTRA; end
            `OP_RESET_INSN:  begin b = `CLK_RESET_BEST; x = `CLK_RESET_XTRA; end
            `OP_FAULT_SHORT: begin b = `CLK_FLT_S_BEST; x = `CLK_FLT_S_XTRA; end
            `OP_FAULT_LONG:  begin b = `CLK_FLT_L_BEST; x = `CLK_FLT_L_XTRA; end
            `OP_RET_SHORT:   begin b = `CLK_RET_S_BEST; x = `CLK_RET_S_XTRA; end
            `OP_RET_LONG:    begin b = `CLK_RET_L_BEST; x = `CLK_RET_L_XTRA; end
            default:         begin b = `CLK_RET_T_BEST; x = `CLK_RET_T_XTRA; end
         endcase
         // Cache case adds one clock to short saves and to every frame return only
         if (c == 2'd0)
            budget = b;
         else if (c == 2'd1 && (o == `OP_INT_ISTACK || o == `OP_INT_MSTACK ||
                  o == `OP_RESET_INSN || o == `OP_FAULT_LONG))
            budget = b;
         else if (c == 2'd1)
            budget = b + 10'h001;
         else
            budget = b + x;
      end
   endfunction

   // Operand read count of an operation
   function [4:0] reads;
      input [2:0] o;
      begin
         case (o)
            `OP_INT_ISTACK, `OP_INT_MSTACK: reads = `RD_INT;
            `OP_RESET_INSN:  reads = `RD_RESET;
            `OP_FAULT_SHORT, `OP_FAULT_LONG: reads = `RD_FLT;
            `OP_RET_SHORT:   reads = `RD_RET_S;
            `OP_RET_LONG:    reads = `RD_RET_L;
            default:         reads = `RD_RET_T;
         endcase
      end
   endfunction

   // Write count of an operation
   function [4:0] writes;
      input [2:0] o;
      begin
         case (o)
            `OP_INT_ISTACK:  writes = `WR_INT_I;
            `OP_INT_MSTACK:  writes = `WR_INT_M;
            `OP_FAULT_SHORT: writes = `WR_FLT_S;
            `OP_FAULT_LONG:  writes = `WR_FLT_L;
            default:         writes = `WR_NONE;
         endcase
      end
   endfunction

   // Prefetch count, worst case only
   function [1:0] prefetches;
      input [2:0] o;
      input [1:0] c;
      begin
         if (c < 2'd2)
            prefetches = `PF_NONE;
         else if (o == `OP_RESET_INSN)
            prefetches = `PF_RESET;
         // A throwaway frame needs no prefetch of its own
         else if (o == `OP_RET_THROW)
            prefetches = `PF_NONE;
         else
            prefetches = `PF_WORST;
      end
   endfunction

   wire [9:0] first_len = budget(op, timing_case);
   wire [9:0] chain_len = budget(next_q, case_q);
   wire       next_ok   = (next_q != `OP_RET_THROW);

   // Sequence state, down counter and bus-cycle scheduling
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q        <= IDLE;
         op_q        <= 3'h0;
         next_q      <= 3'h0;
         chain_q     <= 1'b0;
         case_q      <= 2'd0;
         left_q      <= 10'h000;
         used_q      <= 10'h000;
         rd_left_q   <= 5'h00;
         wr_left_q   <= 5'h00;
         pf_left_q   <= 2'h0;
         busy_q      <= 1'b0;
         done_q      <= 1'b0;
         clocks_q    <= 10'h000;
         rd_cyc_q    <= 1'b0;
         pf_cyc_q    <= 1'b0;
         wr_cyc_q    <= 1'b0;
         reset_out_q <= 1'b0;
         lowest_address_input_q <= 1'b1;
         width_select_q         <= 1'b1;
      end else begin
         done_q   <= 1'b0;
         rd_cyc_q <= 1'b0;
         pf_cyc_q <= 1'b0;
         wr_cyc_q <= 1'b0;
         lowest_address_input_q <= 1'b1;
         width_select_q         <= 1'b1;
         case (st_q)
            IDLE: begin
               if (start) begin
                  op_q      <= op;
                  next_q    <= next_op;
                  case_q    <= timing_case;
                  chain_q   <= (op == `OP_RET_THROW);
                  left_q    <= first_len;
                  used_q    <= 10'h000;
                  rd_left_q <= reads(op);
                  wr_left_q <= writes(op);
                  pf_left_q <= prefetches(op, timing_case);
                  busy_q    <= 1'b1;
                  reset_out_q <= (op == `OP_RESET_INSN);
                  st_q      <= RUN;
               end
            end
            RUN: begin
               used_q <= used_q + 10'h001;
               left_q <= left_q - 10'h001;
               // Reads first, then writes, prefetches last
               if (rd_left_q != 5'h00) begin
                  rd_cyc_q  <= 1'b1;
                  rd_left_q <= rd_left_q - 5'h01;
               end else if (wr_left_q != 5'h00) begin
                  wr_cyc_q  <= 1'b1;
                  wr_left_q <= wr_left_q - 5'h01;
               end else if (pf_left_q != 2'h0) begin
                  pf_cyc_q  <= 1'b1;
                  pf_left_q <= pf_left_q - 2'h1;
               end
               if (left_q == 10'h001) begin
                  if (chain_q && next_ok) begin
                     chain_q   <= 1'b0;
                     op_q      <= next_q;
                     left_q    <= chain_len;
                     rd_left_q <= reads(next_q);
                     wr_left_q <= writes(next_q);
                     pf_left_q <= prefetches(next_q, case_q);
                  end else begin
                     st_q <= FIN;
                  end
               end
            end
            FIN: begin
               busy_q      <= 1'b0;
               done_q      <= 1'b1;
               reset_out_q <= 1'b0;
               clocks_q    <= used_q;
               st_q        <= IDLE;
            end
            default: st_q <= IDLE;
         endcase
      end
   end

   // Coprocessor transfer agent
   cp_xfer u_cp (
      .clk         (clk),
      .rstn        (rstn),
      .cp_req      (cp_req),
      .cp_id       (cp_id),
      .cp_write    (cp_write),
      .cp_wdata    (cp_wdata),
      .cp_done_q   (cp_done),
      .cp_err_q    (cp_err),
      .cp_rdata_q  (cp_rdata),
      .bus_grant   (bus_grant),
      .as_n_q      (as_n),
      .rw_q        (rw),
      .sel_id_q    (sel_id),
      .bus_wdata_q (bus_wdata),
      .dsack_n     (dsack_n),
      .berr_n      (berr_n),
      .addr_fault  (addr_fault),
      .bus_rdata   (bus_rdata)
   );
endmodule

// [rtl/exc_seq_map.vh]
// Constants for the exception sequencer: cycle budgets and bus-cycle counts.
// Assumes inclusion by the sequencer files; definitions only.
`ifndef EXC_SEQ_MAP_VH
`define EXC_SEQ_MAP_VH
// Operation codes
`define OP_INT_ISTACK   3'h0
`define OP_INT_MSTACK   3'h1
`define OP_RESET_INSN   3'h2
`define OP_FAULT_SHORT  3'h3
`define OP_FAULT_LONG   3'h4
`define OP_RET_SHORT    3'h5
`define OP_RET_LONG     3'h6
`define OP_RET_THROW    3'h7
// Best-case totals in clocks
`define CLK_INT_I_BEST  10'h01A
`define CLK_INT_M_BEST  10'h029
`define CLK_RESET_BEST  10'h206
`define CLK_FLT_S_BEST  10'h02A
`define CLK_FLT_L_BEST  10'h04F
`define CLK_RET_S_BEST  10'h02A
`define CLK_RET_L_BEST  10'h05B
`define CLK_RET_T_BEST  10'h00F
// Worst-case extra clocks (prefetches added)
`define CLK_INT_I_XTRA  10'h007
`define CLK_INT_M_XTRA  10'h007
`define CLK_RESET_XTRA  10'h001
`define CLK_FLT_S_XTRA  10'h008
`define CLK_FLT_L_XTRA  10'h007
`define CLK_RET_S_XTRA  10'h003
`define CLK_RET_L_XTRA  10'h003
`define CLK_RET_T_XTRA  10'h018
// Operand reads
`define RD_INT          5'h02
`define RD_RESET        5'h00
`define RD_FLT          5'h01
`define RD_RET_S        5'h0A
`define RD_RET_L        5'h18
`define RD_RET_T        5'h04
// Writes
`define WR_INT_I        5'h04
`define WR_INT_M        5'h08
`define WR_NONE         5'h00
`define WR_FLT_S        5'h0A
`define WR_FLT_L        5'h18
// Prefetches in the worst case
`define PF_WORST        2'h2
`define PF_RESET        2'h1
`define PF_NONE         2'h0
// Coprocessor count
`define CP_MAX          3'h7
`endif

// [rtl/cp_xfer.v]
// Coprocessor transfer agent: runs a requested transfer as an async bus
// cycle and returns the answer. Assumes cp request inputs synchronous to clk.
`timescale 1ns/1ps
`include "exc_seq_map.vh"
module cp_xfer (
   // Clock and reset
   input  wire        clk,
   input  wire        rstn,
   // Coprocessor request
   input  wire        cp_req,
   input  wire [2:0]  cp_id,
   input  wire        cp_write,
   input  wire [31:0] cp_wdata,
   output reg         cp_done_q,
   output reg         cp_err_q,
   output reg  [31:0] cp_rdata_q,
   // Bus grant from arbitration
   input  wire        bus_grant,
   // Async bus
   output reg         as_n_q,
   output reg         rw_q,
   output reg  [2:0]  sel_id_q,
   output reg  [31:0] bus_wdata_q,
   input  wire        dsack_n,
   input  wire        berr_n,
   input  wire        addr_fault,
   input  wire [31:0] bus_rdata
);
   localparam IDLE = 2'd0;
   localparam WAIT = 2'd1;
   localparam RUN  = 2'd2;
   reg [1:0] st_q;
   wire      id_ok = (cp_id != 3'h0) && (cp_id <= `CP_MAX);

   // Bus cycle sequencer; ends on acknowledge, not on a clock count
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q        <= IDLE;
         as_n_q      <= 1'b1;
         rw_q        <= 1'b1;
         sel_id_q    <= 3'h0;
         bus_wdata_q <= 32'h0000_0000;
         cp_done_q   <= 1'b0;
         cp_err_q    <= 1'b0;
         cp_rdata_q  <= 32'h0000_0000;
      end else begin
         cp_done_q <= 1'b0;
         cp_err_q  <= 1'b0;
         case (st_q)
            IDLE: begin
               if (cp_req) begin
                  if (!id_ok || addr_fault) begin
                     cp_done_q <= 1'b1;
                     cp_err_q  <= 1'b1;
                  end else begin
                     sel_id_q    <= cp_id;
                     rw_q        <= ~cp_write;
                     bus_wdata_q <= cp_wdata;
                     st_q        <= WAIT;
                  end
               end
            end
            WAIT: begin
               if (bus_grant) begin
                  as_n_q <= 1'b0;
                  st_q   <= RUN;
               end
            end
            RUN: begin
               if (!berr_n) begin
                  as_n_q    <= 1'b1;
                  cp_done_q <= 1'b1;
                  cp_err_q  <= 1'b1;
                  st_q      <= IDLE;
               end else if (!dsack_n) begin
                  as_n_q     <= 1'b1;
                  cp_done_q  <= 1'b1;
                  cp_rdata_q <= bus_rdata;
                  st_q       <= IDLE;
               end
            end
            default: st_q <= IDLE;
         endcase
      end
   end
endmodule

// [tb/exc_seq_props.sv]
// Checker for the exception sequencer and its coprocessor bus agent.
// Assumes binding onto exc_seq; sees only that module's ports.
`timescale 1ns/1ps
module exc_seq_props (
   // Clock and reset
   input logic        clk,
   input logic        rstn,
   // Sequencer
   input logic        start,
   input logic        busy_q,
   input logic        done_q,
   input logic        rd_cyc_q,
   input logic        wr_cyc_q,
   input logic        reset_out_q,
   // Coprocessor agent and bus
   input logic        cp_done,
   input logic        cp_err,
   input logic        bus_grant,
   input logic        as_n,
   input logic [2:0]  sel_id,
   input logic        dsack_n,
   input logic        berr_n,
   // Width straps
   input logic        lowest_address_input_q,
   input logic        width_select_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Steps of a sequence run and of a bus cycle
   sequence op_taken;
      start && !busy_q;
   endsequence
   sequence cyc_open;
      !as_n && dsack_n && berr_n;
   endsequence
   sequence cyc_ack;
      !as_n && !dsack_n;
   endsequence
   sequence cyc_fault;
      !as_n && !berr_n;
   endsequence

   // Length of the current run; the worst reset instruction is the longest
   localparam int RUN_MAX = 530;
   logic [9:0] run_cnt_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         run_cnt_q <= 10'h000;
      else if (busy_q)
         run_cnt_q <= run_cnt_q + 10'h001;
      else
         run_cnt_q <= 10'h000;
   end

   done_single_a: assert property (done_q |=> !done_q)
      else $error("done pulse longer than one cycle");
   done_bound_a: assert property (run_cnt_q <= RUN_MAX)
      else $error("operation never finished");
   start_taken_a: assert property (op_taken |=> busy_q)
      else $error("start in idle not taken");
   reset_quiet_a: assert property
      (reset_out_q |-> !rd_cyc_q && !wr_cyc_q)
      else $error("bus traffic during reset instruction");
   strobe_hold_a: assert property (cyc_open |=> !as_n)
      else $error("strobe dropped before acknowledge");
   ack_finish_a: assert property (cyc_ack |=> cp_done && as_n)
      else $error("acknowledge not turned into done");
   berr_report_a: assert property (cyc_fault |=> cp_done && cp_err)
      else $error("bus error not reported");
   grant_first_a: assert property ($fell(as_n) |-> $past(bus_grant))
      else $error("bus cycle started without grant");
   err_with_done_a: assert property (cp_err |-> cp_done)
      else $error("error flag without done");
   id_valid_a: assert property (!as_n |-> sel_id != 3'h0)
      else $error("coprocessor cycle with id zero");
   straps_high_a: assert property
      (lowest_address_input_q && width_select_q)
      else $error("width straps not high");
endmodule

bind exc_seq exc_seq_props i_exc_seq_props (
   .clk(clk), .rstn(rstn), .start(start), .busy_q(busy_q), .done_q(done_q),
   .rd_cyc_q(rd_cyc_q), .wr_cyc_q(wr_cyc_q), .reset_out_q(reset_out_q),
   .cp_done(cp_done), .cp_err(cp_err), .bus_grant(bus_grant), .as_n(as_n),
   .sel_id(sel_id), .dsack_n(dsack_n), .berr_n(berr_n),
   .lowest_address_input_q(lowest_address_input_q),
   .width_select_q(width_select_q)
);

// [tb/cp_model.sv]
// Floating-point coprocessor model: a bus slave with one word per id.
// Assumes the bench sets wait states and bus-error answers per cycle.
`timescale 1ns/1ps
module cp_model (
   // Clock and reset
   input  logic        clk,
   input  logic        rstn,
   // Bench controls
   input  logic [3:0]  wait_cyc,
   input  logic        give_berr,
   // Async bus, slave side
   input  logic        as_n,
   input  logic        rw,
   input  logic [2:0]  sel_id,
   input  logic [31:0] bus_wdata,
   output logic        dsack_n,
   output logic        berr_n,
   output logic [31:0] bus_rdata
);
   logic [31:0] word_q [0:7];
   logic [3:0]  cnt_q;

   // Answer each cycle after a chosen wait; no shared phase assumed
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dsack_n   <= 1'b1;
         berr_n    <= 1'b1;
         cnt_q     <= 4'h0;
         bus_rdata <= 32'h0000_0000;
      end else if (as_n || !dsack_n || !berr_n) begin
         // Released: data lines are inverted every cycle, from the last word on
         dsack_n   <= 1'b1;
         berr_n    <= 1'b1;
         cnt_q     <= 4'h0;
         bus_rdata <= ~bus_rdata;
      end else if (cnt_q != wait_cyc) begin
         cnt_q <= cnt_q + 4'h1; // Wait states, 0 to 15 cycles
      end else if (give_berr) begin
         berr_n <= 1'b0;
      end else begin
         // Slave answer, each id its own storage
         dsack_n <= 1'b0;
         if (rw)
            bus_rdata <= word_q[sel_id];
         else
            word_q[sel_id] <= bus_wdata;
      end
   end
endmodule

// [tb/test_exc_seq.sv]
// Self-checking bench for exc_seq with a coprocessor model on its bus.
// Assumes a 10 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module test_exc_seq;
   logic        clk, rstn, start, cp_req, cp_write, bus_grant;
   logic        addr_fault, give_berr, cp_done, cp_err, as_n, rw;
   logic        busy_q, done_q, rd_cyc_q, pf_cyc_q, wr_cyc_q, reset_out_q;
   logic        dsack_n, berr_n, lai_q, wsel_q;
   logic [2:0]  op, next_op, cp_id, sel_id;
   logic [1:0]  timing_case;
   logic [3:0]  wait_cyc;
   logic [9:0]  clocks_q;
   logic [31:0] cp_wdata, cp_rdata, bus_wdata, bus_rdata;
   int          error_cnt, tests_run;

   exc_seq i_exc_seq (.clk(clk), .rstn(rstn), .start(start), .op(op),
      .timing_case(timing_case), .next_op(next_op), .busy_q(busy_q),
      .done_q(done_q), .clocks_q(clocks_q), .rd_cyc_q(rd_cyc_q),
      .pf_cyc_q(pf_cyc_q), .wr_cyc_q(wr_cyc_q), .reset_out_q(reset_out_q),
      .cp_req(cp_req), .cp_id(cp_id), .cp_write(cp_write),
      .cp_wdata(cp_wdata), .cp_done(cp_done), .cp_err(cp_err),
      .cp_rdata(cp_rdata), .bus_grant(bus_grant), .as_n(as_n), .rw(rw),
      .sel_id(sel_id), .bus_wdata(bus_wdata), .dsack_n(dsack_n),
      .berr_n(berr_n), .addr_fault(addr_fault), .bus_rdata(bus_rdata),
      .lowest_address_input_q(lai_q), .width_select_q(wsel_q));
   cp_model i_cp_model (.clk(clk), .rstn(rstn), .wait_cyc(wait_cyc),
      .give_berr(give_berr), .as_n(as_n), .rw(rw), .sel_id(sel_id),
      .bus_wdata(bus_wdata), .dsack_n(dsack_n), .berr_n(berr_n),
      .bus_rdata(bus_rdata));

   // Clock generator
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task give_verdict;
      if (error_cnt == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One sequencer run, counting bus strobes until done
   task do_op(input logic [2:0] o, input logic [1:0] tc, input logic [2:0] nx,
              input int eclk, input int erd, input int ewr, input int epf);
      int rd, wr, pf, rs, n;
      rd = 0; wr = 0; pf = 0; rs = 0;
      @(posedge clk);
      start <= 1'b1; op <= o; timing_case <= tc; next_op <= nx;
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 1200 && done_q !== 1'b1; n++) begin
         @(negedge clk);
         rd += (rd_cyc_q === 1'b1);
         wr += (wr_cyc_q === 1'b1);
         pf += (pf_cyc_q === 1'b1);
         rs += (reset_out_q === 1'b1);
      end
      check("clocks", {22'h0, clocks_q}, eclk);
      check("reads", rd, erd);
      check("writes", wr, ewr);
      check("prefetches", pf, epf);
      check("reset_out", rs != 0, o == 3'h2);
   endtask

   task t_int_entry;
      do_op(3'h0, 2'h0, 3'h0, 26, 2, 4, 0);
      do_op(3'h0, 2'h1, 3'h0, 26, 2, 4, 0);
      do_op(3'h0, 2'h2, 3'h0, 33, 2, 4, 2);
      do_op(3'h1, 2'h0, 3'h0, 41, 2, 8, 0);
      do_op(3'h1, 2'h3, 3'h0, 48, 2, 8, 2);
   endtask

   task t_reset_insn;
      do_op(3'h2, 2'h0, 3'h0, 518, 0, 0, 0);
      do_op(3'h2, 2'h2, 3'h0, 519, 0, 0, 1);
   endtask

   task t_fault_save;
      do_op(3'h3, 2'h0, 3'h0, 42, 1, 10, 0);
      do_op(3'h3, 2'h2, 3'h0, 50, 1, 10, 2);
      do_op(3'h4, 2'h0, 3'h0, 79, 1, 24, 0);
      do_op(3'h4, 2'h1, 3'h0, 79, 1, 24, 0);
      do_op(3'h4, 2'h2, 3'h0, 86, 1, 24, 2);
      do_op(3'h3, 2'h1, 3'h0, 43, 1, 10, 0);
   endtask

   task t_frame_return;
      do_op(3'h5, 2'h0, 3'h0, 42, 10, 0, 0);
      do_op(3'h5, 2'h1, 3'h0, 43, 10, 0, 0);
      do_op(3'h6, 2'h0, 3'h0, 91, 24, 0, 0);
      do_op(3'h6, 2'h1, 3'h0, 92, 24, 0, 0);
      do_op(3'h5, 2'h2, 3'h0, 45, 10, 0, 2);
      do_op(3'h6, 2'h2, 3'h0, 94, 24, 0, 2);
      do_op(3'h7, 2'h2, 3'h5, 84, 14, 0, 2);
      do_op(3'h7, 2'h0, 3'h5, 57, 14, 0, 0);
      do_op(3'h7, 2'h1, 3'h6, 108, 28, 0, 0);
   endtask

   // A second start while busy must leave the first run untouched
   task t_busy_refused;
      int n;
      @(posedge clk);
      start <= 1'b1; op <= 3'h0; timing_case <= 2'h0;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
      start <= 1'b1; op <= 3'h1;
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 100 && done_q !== 1'b1; n++) @(negedge clk);
      check("refused_clocks", {22'h0, clocks_q}, 26);
      repeat (3) @(negedge clk);
      check("refused_busy", busy_q, 1'b0);
   endtask

   // One coprocessor transfer; grant is withheld for two cycles
   task cp_op(input logic [2:0] id, input logic wr, input logic [31:0] d,
              input logic [3:0] w, input logic be, input logic af,
              input logic ee);
      int n, lo;
      logic [2:0] sid;
      logic srw;
      lo = 0; sid = 3'h0; srw = 1'b0;
      @(posedge clk);
      cp_req <= 1'b1; cp_id <= id; cp_write <= wr; cp_wdata <= d;
      wait_cyc <= w; give_berr <= be; addr_fault <= af;
      for (n = 0; n < 64 && cp_done !== 1'b1; n++) begin
         @(posedge clk);
         cp_req <= 1'b0;
         bus_grant <= (n >= 2);
         @(negedge clk);
         if (as_n === 1'b0) begin
            lo++;
            sid = sel_id;
            srw = rw;
         end
      end
      check("cp_err", cp_err, ee);
      check("cp_cycle", lo != 0, !af && id != 3'h0);
      if (lo != 0) check("cp_sel", {srw, sid}, {!wr, id});
      if (!wr && !ee) check("cp_rdata", cp_rdata, d);
      @(posedge clk);
      addr_fault <= 1'b0;
      bus_grant <= 1'b0;
   endtask

   task t_cp_rw;
      int i;
      for (i = 1; i < 8; i++)
         cp_op(i, 1'b1, 32'hA5C3_0000 | i, i % 3, 1'b0, 1'b0, 1'b0);
      for (i = 7; i > 0; i--)
         cp_op(i, 1'b0, 32'hA5C3_0000 | i, i % 4, 1'b0, 1'b0, 1'b0);
   endtask

   task t_cp_faults;
      cp_op(3'h3, 1'b0, 32'h0000_0000, 4'h1, 1'b1, 1'b0, 1'b1);
      cp_op(3'h2, 1'b0, 32'h0000_0000, 4'h0, 1'b0, 1'b1, 1'b1);
      cp_op(3'h0, 1'b1, 32'h0000_0000, 4'h0, 1'b0, 1'b0, 1'b1);
      cp_op(3'h2, 1'b0, 32'hA5C3_0002, 4'h2, 1'b0, 1'b0, 1'b0);
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict;
   end

   // Main sequence
   initial begin
      error_cnt = 0; tests_run = 0;
      rstn = 1'b0; start = 1'b0; op = 3'h0; next_op = 3'h0;
      timing_case = 2'h0; cp_req = 1'b0; cp_id = 3'h0; cp_write = 1'b0;
      cp_wdata = 32'h0000_0000; bus_grant = 1'b0; addr_fault = 1'b0;
      wait_cyc = 4'h0; give_berr = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      check("straps", {lai_q, wsel_q}, 2'h3);
      t_int_entry;
      t_reset_insn;
      t_fault_save;
      t_frame_return;
      t_busy_refused;
      t_cp_rw;
      t_cp_faults;
      give_verdict;
   end
endmodule
